// file: st_pkg.sv
// constants, thresholds and status carrier for the continuous self-test monitor
package st_pkg;
  // system clock and internal oscillator f0 (typical)
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned F0_HZ = 15_200;
  // system clock cycles per f0 tick, rounded down
  localparam int unsigned F0_DIV = CLK_HZ / F0_HZ;
  // self-test tone is f0/32: each polarity lasts half of that
  localparam int unsigned ST_TONE_DIV = 32;
  localparam logic [3:0] ST_HALF_LAST = 4'(ST_TONE_DIV / 2 - 1);
  // first order filter y += (x - y)/64, one update per 16 f0 ticks
  localparam int unsigned LPF_SHIFT = 6;
  // data widths
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned SUM_W = 20;
  localparam int unsigned ACC_W = SAMPLE_W + LPF_SHIFT;
  // register map
  localparam logic [7:0] ADDR_SELFTEST = 8'h04;
  // limits on the filtered value: narrow window sets the fault bit only
  localparam logic signed [15:0] FAULT_LO = 16'sh08BF;
  localparam logic signed [15:0] FAULT_HI = 16'sh0B3F;
  // wide window: outside it the rate data is invalid
  localparam logic signed [15:0] VALID_LO = 16'sh04FF;
  localparam logic signed [15:0] VALID_HI = 16'sh0EFF;
  // filter starts mid-window so reset does not flag a false error
  localparam logic signed [15:0] ST_RESET_VALUE = 16'sh09FF;
  // validity field encodings
  localparam logic [1:0] VALIDITY_OK = 2'h1;
  localparam logic [1:0] VALIDITY_BAD = 2'h0;
  // reset values of the divider and read data
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [15:0] RD_RESET = 16'h0000;

  // status travelling beside the rate word
  typedef struct packed {
    logic selftest_fault_bit;
    logic [1:0] sensor_validity_field;
  } sensor_status_t;
endpackage

// file: st_lpf.sv
// first order low-pass filter for the self-test difference amplitude
`timescale 1ns/1ps
module st_lpf
  import st_pkg::*;
#(
  parameter int unsigned SHIFT = LPF_SHIFT
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic upd,
  input wire logic signed [SAMPLE_W-1:0] x_in,
  output logic signed [SAMPLE_W-1:0] y_out
);
  // accumulator holds y scaled by 2^SHIFT, keeps the fraction bits
  logic signed [ACC_W-1:0] acc_ff;
  logic signed [ACC_W-1:0] nxt_acc;
  localparam logic signed [ACC_W-1:0] ACC_RESET = ACC_W'(ST_RESET_VALUE) <<< SHIFT;

  // y[n] = (x + 63 y[n-1]) / 64, one step per update strobe
  always_comb
  begin
    nxt_acc = acc_ff;
    if (upd)
    begin
      nxt_acc = acc_ff + ACC_W'(x_in) - (acc_ff >>> SHIFT);
    end
  end

  // register, frozen while ce is low
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      acc_ff <= ACC_RESET;
    else if (ce)
      acc_ff <= nxt_acc;
  end

  assign y_out = acc_ff[ACC_W-1:SHIFT];
endmodule

// file: continuous_selftest_monitor.sv
// continuous self-test sequencer, filter, limit compare and rate output
`timescale 1ns/1ps
module continuous_selftest_monitor
  import st_pkg::*;
#(
  parameter int unsigned F0_CYCLES = F0_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic signed [SAMPLE_W-1:0] sense_sample,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  output logic st_drive_pos,
  output logic signed [SAMPLE_W-1:0] rate_output_word,
  output sensor_status_t sensor_status,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  // f0 tick divider
  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic tick_ff;
  logic nxt_tick;
  localparam logic [15:0] DIV_LAST = 16'(F0_CYCLES - 1);

  // the free running divider stands in for the internal oscillator
  always_comb
  begin
    nxt_div = div_ff + 16'h0001;
    nxt_tick = 1'b0;
    if (div_ff == DIV_LAST)
    begin
      nxt_div = DIV_RESET;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      div_ff <= DIV_RESET;
      tick_ff <= 1'b0;
    end
    else if (ce)
    begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // sequencer: polarity, half counter, per-half sums
  logic [3:0] half_ff;
  logic [3:0] nxt_half;
  logic pol_ff; // high while the positive deflection is applied
  logic nxt_pol;
  logic signed [SUM_W-1:0] acc_ff;
  logic signed [SUM_W-1:0] nxt_acc;
  logic signed [SUM_W-1:0] sum_p_ff;
  logic signed [SUM_W-1:0] nxt_sum_p;
  logic signed [SUM_W-1:0] sum_n_ff;
  logic signed [SUM_W-1:0] nxt_sum_n;
  logic upd_ff; // one cycle after each completed half
  logic nxt_upd;
  logic half_end;
  logic signed [SUM_W-1:0] acc_plus;

  assign half_end = tick_ff && (half_ff == ST_HALF_LAST);
  assign acc_plus = acc_ff + SUM_W'(sense_sample);

  // runs with no command at f0/32, well above the rate bandwidth
  always_comb
  begin
    nxt_half = half_ff;
    nxt_pol = pol_ff;
    nxt_acc = acc_ff;
    nxt_sum_p = sum_p_ff;
    nxt_sum_n = sum_n_ff;
    nxt_upd = 1'b0;
    if (half_end)
    begin
      // close the half: bank its sum and swap polarity
      nxt_half = 4'h0;
      nxt_pol = !pol_ff;
      nxt_acc = '0;
      nxt_upd = 1'b1;
      if (pol_ff)
        nxt_sum_p = acc_plus;
      else
        nxt_sum_n = acc_plus;
    end
    else if (tick_ff)
    begin
      // sample belongs to the deflection now applied
      nxt_half = half_ff + 4'h1;
      nxt_acc = acc_plus;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      half_ff <= 4'h0;
      pol_ff <= 1'b1;
      acc_ff <= '0;
      sum_p_ff <= '0;
      sum_n_ff <= '0;
      upd_ff <= 1'b0;
    end
    else if (ce)
    begin
      half_ff <= nxt_half;
      pol_ff <= nxt_pol;
      acc_ff <= nxt_acc;
      sum_p_ff <= nxt_sum_p;
      sum_n_ff <= nxt_sum_n;
      upd_ff <= nxt_upd;
    end
  end

  // rate and difference from the last positive and negative halves
  logic signed [SUM_W:0] total_w;
  logic signed [SUM_W:0] diff_w;
  logic signed [SAMPLE_W-1:0] diff_amp;
  logic signed [SAMPLE_W-1:0] filt;
  assign total_w = (SUM_W+1)'(sum_p_ff) + (SUM_W+1)'(sum_n_ff);
  assign diff_w = (SUM_W+1)'(sum_p_ff) - (SUM_W+1)'(sum_n_ff);
  // per-sample difference; wraps only for a far out-of-range sense channel
  assign diff_amp = diff_w[SUM_W-1:4];

  st_lpf #(.SHIFT(LPF_SHIFT)) u_lpf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .upd(upd_ff),
    .x_in(diff_amp),
    .y_out(filt)
  );

  // output, status and read registers
  logic signed [SAMPLE_W-1:0] rate_ff;
  logic signed [SAMPLE_W-1:0] nxt_rate;
  sensor_status_t status_ff;
  sensor_status_t nxt_status;
  logic rd_valid_ff;
  logic nxt_rd_valid;
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;
  logic narrow_bad;
  logic wide_bad;

  // limit compares on the filtered value
  assign narrow_bad = (filt < FAULT_LO) || (filt > FAULT_HI);
  assign wide_bad = (filt < VALID_LO) || (filt > VALID_HI);

  always_comb
  begin
    nxt_rate = rate_ff;
    // averaging a full pos/neg pair removes the test deflection
    if (upd_ff)
      nxt_rate = total_w[SUM_W:5]; // signed, clockwise positive
    nxt_status.selftest_fault_bit = narrow_bad || wide_bad;
    nxt_status.sensor_validity_field = wide_bad ? VALIDITY_BAD : VALIDITY_OK;
    nxt_rd_valid = rd_req;
    nxt_rd_data = RD_RESET;
    // unmapped addresses answer zero
    if (rd_req && (rd_addr == ADDR_SELFTEST))
      nxt_rd_data = filt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rate_ff <= '0;
      status_ff <= '{selftest_fault_bit: 1'b0, sensor_validity_field: VALIDITY_OK};
      rd_valid_ff <= 1'b0;
      rd_data_ff <= RD_RESET;
    end
    else if (ce)
    begin
      rate_ff <= nxt_rate;
      status_ff <= nxt_status;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign st_drive_pos = pol_ff;
  assign rate_output_word = rate_ff;
  assign sensor_status = status_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;

  // checks
  property p_pol_swap;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && half_end) |=> (st_drive_pos != $past(st_drive_pos)) ##1 (!$past(ce) || !upd_ff);
  endproperty
  a_pol_swap: assert property (p_pol_swap) else $error("polarity did not swap at half end");

  property p_pol_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    $changed(st_drive_pos) |-> $past(half_end) && upd_ff;
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("polarity changed mid half");

  property p_rate_avg;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && upd_ff) |=> rate_output_word == $past(total_w[SUM_W:5]);
  endproperty
  a_rate_avg: assert property (p_rate_avg) else $error("rate word not pair average");

  property p_rate_sign;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && upd_ff && total_w > 0) |=> !rate_output_word[SAMPLE_W-1];
  endproperty
  a_rate_sign: assert property (p_rate_sign) else $error("positive rotation gave negative word");

  property p_rate_neg;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && upd_ff && total_w < -32) |=> rate_output_word[SAMPLE_W-1];
  endproperty
  a_rate_neg: assert property (p_rate_neg) else $error("negative rotation gave positive word");

  property p_filt_step;
    @(posedge clk_sys) disable iff (!rst_b)
    $changed(filt) |-> $past(upd_ff) && $past(ce);
  endproperty
  a_filt_step: assert property (p_filt_step) else $error("filter moved without update");

  property p_wide;
    @(posedge clk_sys) disable iff (!rst_b)
    ce |=> sensor_status.sensor_validity_field == ($past(wide_bad) ? VALIDITY_BAD : VALIDITY_OK);
  endproperty
  a_wide: assert property (p_wide) else $error("validity field disagrees with wide window");

  property p_narrow;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && narrow_bad && !wide_bad) |=> sensor_status.selftest_fault_bit &&
      sensor_status.sensor_validity_field == VALIDITY_OK;
  endproperty
  a_narrow: assert property (p_narrow) else $error("mild error not flagged as fault only");

  property p_severe;
    @(posedge clk_sys) disable iff (!rst_b)
    sensor_status.sensor_validity_field == VALIDITY_BAD |-> sensor_status.selftest_fault_bit;
  endproperty
  a_severe: assert property (p_severe) else $error("invalid data without fault bit");

  property p_read;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && rd_req && rd_addr == ADDR_SELFTEST) |=> rd_valid && rd_data == $past(filt);
  endproperty
  a_read: assert property (p_read) else $error("self-test read returned wrong value");

  c_half: cover property (@(posedge clk_sys) disable iff (!rst_b) half_end ##1 upd_ff);
  c_fault: cover property (@(posedge clk_sys) disable iff (!rst_b) sensor_status.selftest_fault_bit);
  c_invalid: cover property (@(posedge clk_sys) disable iff (!rst_b)
    sensor_status.sensor_validity_field == VALIDITY_BAD);
  // the host turns the address over once the request is taken, so look at it on the request cycle
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_b) (rd_req && rd_addr == ADDR_SELFTEST) ##1 rd_valid);
endmodule

// file: st_host.sv
// host-side model that issues register reads and captures the answers
`timescale 1ns/1ps
module st_host
(
  input wire logic clk_sys,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic rd_req,
  output logic [7:0] rd_addr
);
  // idle until the bench asks for a read
  initial
  begin
    rd_req = 1'b0;
    rd_addr = 8'hA5;
  end
  // one-cycle request; lat counts edges past the taking edge
  task automatic read(input logic [7:0] a, output logic [15:0] d, output int lat);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_addr <= a;
    lat = 0;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    // released address turns over so a stale decode cannot pass
    rd_addr <= ~a;
    #1;
    while (rd_valid !== 1'b1 && lat < 4)
    begin
      @(posedge clk_sys);
      #1;
      lat++;
    end
    d = rd_data;
  endtask
endmodule

// file: test_continuous_selftest_monitor.sv
// self-checking bench for the continuous self-test monitor
`timescale 1ns/1ps
module test_continuous_selftest_monitor
  import st_pkg::*;
;
  localparam int unsigned F0C = 4; // short f0 period keeps the run small
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1; // low only during the freeze scenario
  logic signed [15:0] sense_sample = '0;
  logic signed [15:0] rate_in = '0; // true rotation, clockwise positive
  logic signed [15:0] dfl = 16'sh0500; // test deflection size
  logic signed [15:0] corner [3] = '{16'sh0001, -16'sh0001, 16'sh0000};
  int tg [5] = '{500, 1000, 1650, 2100, 1280}; // filtered value lands near 2x
  logic rd_req;
  logic [7:0] rd_addr;
  logic st_drive_pos;
  logic signed [15:0] rate_output_word;
  sensor_status_t sensor_status;
  logic rd_valid;
  logic [15:0] rd_data;
  logic [15:0] rv;
  int lat;
  int rv0; // filtered value right after the first step of a new deflection
  int ev; // expected filtered value part way through a step
  int k;
  int n;
  int errors = 0;
  int check_count = 0;
  longint t0;
  always #5 clk_sys = ~clk_sys;
  // front end: deflection follows the drive polarity, rate adds on top
  always @(posedge clk_sys) sense_sample <= rate_in + (st_drive_pos ? dfl : -dfl);
  continuous_selftest_monitor #(.F0_CYCLES(F0C)) continuous_selftest_monitor_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .ce(ce), .sense_sample(sense_sample), .rd_req(rd_req), .rd_addr(rd_addr),
    .st_drive_pos(st_drive_pos), .rate_output_word(rate_output_word), .sensor_status(sensor_status),
    .rd_valid(rd_valid), .rd_data(rd_data));
  st_host st_host_inst (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data), .rd_req(rd_req),
    .rd_addr(rd_addr));
  // verdict and end of run
  task automatic test_done();
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // wait for the drive polarity to flip; a stuck sequencer ends the run
  task automatic half();
    logic p;
    int c;
    p = st_drive_pos;
    c = 0;
    while (st_drive_pos === p && c < 200)
    begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    if (c >= 200)
    begin
      errors++;
      test_done();
    end
  endtask
  // expected status for a filtered value; wide window implies narrow
  function automatic sensor_status_t classify(input logic signed [15:0] v);
    classify.selftest_fault_bit = (v < FAULT_LO) || (v > FAULT_HI);
    classify.sensor_validity_field = (v < VALID_LO || v > VALID_HI) ? VALIDITY_BAD : VALIDITY_OK;
  endfunction
  // filter value n steps after y0 with the input held at x; pole is 1 - 2^-shift
  function automatic int lpf_after(input int y0, input int x, input int n);
    real y;
    y = y0;
    for (int i = 0; i < n; i++)
      y = y + (x - y) / (2.0 ** LPF_SHIFT);
    return int'(y);
  endfunction
  // read through the host; a read that never answers ends the run
  task automatic rd(input logic [7:0] a);
    st_host_inst.read(a, rv, lat);
    if (lat >= 4)
    begin
      errors++;
      test_done();
    end
  endtask
  initial
  begin
    void'($urandom(32'h4C96C8AE));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    st_host_inst.read(ADDR_SELFTEST, rv, lat);
    check(rv, ST_RESET_VALUE);
    check(lat, 0);
    check(sensor_status, {1'b0, VALIDITY_OK});
    check(rate_output_word, 16'h0000);
    rd(8'h05);
    check(rv, 16'h0000);
    // polarity keeps flipping with no host command
    half();
    t0 = $time;
    repeat (10) half();
    check(32'(($time - t0) / 10), 10 * 16 * F0C);
    // a low enable freezes everything: the running half stretches by the frozen cycles
    half();
    t0 = $time;
    @(posedge clk_sys);
    ce <= 1'b0;
    // a request while frozen is ignored, so the host runs out its wait
    st_host_inst.read(ADDR_SELFTEST, rv, lat);
    check(lat, 4);
    repeat (94) @(posedge clk_sys);
    ce <= 1'b1;
    half();
    check(32'(($time - t0) / 10), 16 * F0C + 100);
    // rotation sign: corners first, then random
    for (k = 0; k < 8; k++)
    begin
      if (k < 3)
        rate_in <= corner[k];
      else
        rate_in <= 16'($urandom_range(16000)) - 16'sd8000;
      repeat (3) half();
      check(rate_output_word, rate_in);
    end
    // step the deflection through every status class
    for (k = 0; k < 5; k++)
    begin
      dfl <= 16'(tg[k]);
      for (n = 0; n < 256; n++)
      begin
        half();
        rd(ADDR_SELFTEST);
        check(sensor_status, classify(rv));
        if (n > 2)
          check(rate_output_word, rate_in);
        // the first step mixes old and new deflection, so measure the delay from the step after it
        if (k == 0 && n == 0)
          rv0 = int'(rv);
        if (k == 0 && n == 31)
        begin
          ev = lpf_after(rv0, 2 * tg[k], 31);
          check(int'(rv) >= ev - 4 && int'(rv) <= ev + 4, 1);
        end
      end
      check(int'(rv) > 2 * tg[k] - 128 && int'(rv) < 2 * tg[k] + 128, 1);
      check(sensor_status, classify(16'(2 * tg[k])));
    end
    test_done();
  end
endmodule
